//--- core/gat_addr_match.sv
`timescale 1ns/1ps
module gat_addr_match
	import gat_pkg::*;
(
	// Command byte and own address.
	input wire logic [7:0] cmd,
	input wire logic [4:0] my_addr,
	// Decode results.
	output logic is_listen,
	output logic is_talk,
	output logic is_sec,
	output logic addr_hit,
	output logic is_unl,
	output logic is_unt
);
	logic [1:0] grp;
	// Bit 7 never enters the decode.
	assign grp = {cmd[TALK_FLAG_POS], cmd[LISTEN_FLAG_POS]};
	assign addr_hit = cmd[ADDR_MSB:ADDR_LSB] == my_addr;
	assign is_listen = grp == GRP_LISTEN;
	assign is_talk = grp == GRP_TALK;
	assign is_sec = grp == GRP_SEC;
	assign is_unl = cmd[6:0] == CMD_UNLISTEN;
	assign is_unt = cmd[6:0] == CMD_UNTALK;
endmodule // gat_addr_match

//--- core/gat_bus_if.sv
`timescale 1ns/1ps
interface gat_bus_if;
	logic [7:0] dio;
	logic atn;
	logic eoi;
	logic strobe;
	logic [7:0] t_dio;
	logic t_eoi;
	logic t_strobe;
	logic t_hold;
	logic l_hold;
	modport dev (input dio, atn, eoi, strobe, output t_dio, t_eoi, t_strobe, l_hold, input t_hold);
	modport ctl (output dio, atn, eoi, strobe, input t_dio, t_eoi, t_strobe, l_hold, output t_hold);
endinterface

//--- core/gat_controller.sv
`timescale 1ns/1ps
module gat_controller
	import gat_pkg::*;
(
	// Clock and reset.
	input wire logic mclk,
	input wire logic sys_rst,
	// Register port.
	input wire logic [3:0] reg_addr,
	input wire logic [15:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [15:0] reg_rdata,
	// Bus side.
	gat_bus_if.ctl bus
);
	import gat_pkg::*;
	logic [7:0] rx_byte_reg;
	logic rx_v_reg, rx_end_reg;
	logic cmd_wr, data_wr;

	assign cmd_wr = reg_wr && reg_addr == REG_CMD;
	assign data_wr = reg_wr && reg_addr == REG_DATA;

	// Sends one byte per write: command with attention, or data with end line from bit 8.
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			bus.dio <= BYTE_ZERO;
			bus.atn <= 1'b0;
			bus.eoi <= 1'b0;
			bus.strobe <= 1'b0;
			bus.t_hold <= 1'b0;
		end else begin
			bus.strobe <= cmd_wr || data_wr;
			if (cmd_wr || data_wr) begin
				bus.dio <= reg_wdata[7:0];
				bus.atn <= cmd_wr;
				bus.eoi <= data_wr && reg_wdata[8];
			end
			if (reg_wr && reg_addr == REG_STATUS) begin
				bus.t_hold <= reg_wdata[0];
			end
		end
	end

	// Captures bytes from the talker; set wins over a read clear.
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			rx_byte_reg <= BYTE_ZERO;
			rx_v_reg <= 1'b0;
			rx_end_reg <= 1'b0;
		end else if (bus.t_strobe) begin
			rx_byte_reg <= bus.t_dio;
			rx_v_reg <= 1'b1;
			rx_end_reg <= bus.t_eoi;
		end else if (reg_rd && reg_addr == REG_RXDATA) begin
			rx_v_reg <= 1'b0;
		end
	end

	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			reg_rdata <= CNT_ZERO;
		end else if (reg_rd) begin
			unique case (reg_addr)
				REG_STATUS: reg_rdata <= {13'h0000, rx_end_reg, rx_v_reg, bus.l_hold};
				REG_RXDATA: reg_rdata <= {8'h00, rx_byte_reg};
				default: reg_rdata <= CNT_ZERO;
			endcase
		end else begin
			reg_rdata <= CNT_ZERO;
		end
	end
endmodule // gat_controller

//--- core/gat_device.sv
`timescale 1ns/1ps
// Contract
// - attention high means command, low means data
// - data moves only when addressed
// - unique primary address from 0 to 30
// - address in bits 0-4, flags 5, 6
// - bit 7 of commands ignored
// - listen code is address plus 0x20
// - talk code is address plus 0x40
// - secondary code is address plus 0x60
// - secondary follows primary; both must match
// - untalk 0x5f drops talker state
// - other talk address drops talker state
// - unlisten 0x3f drops listener state
// - listener kept until unlisten only
// - termination applies only to data bytes
// - listener ends on termination character
// - talker sends termination character last
// - talker asserts end line on last only
// - listener ends on byte with end line
// - listener stops and holds after count
// - talker waits while t_hold or attention is set
// - any enabled termination ends transfer
module gat_device
	import gat_pkg::*;
(
	// Clock and reset.
	input wire logic mclk,
	input wire logic sys_rst,
	// Bus side.
	gat_bus_if.dev bus,
	// Configuration.
	input wire logic cfg_load,
	input wire logic [4:0] cfg_addr,
	input wire logic cfg_sec_en,
	input wire logic [4:0] cfg_sec_addr,
	input wire logic [7:0] cfg_eos_char,
	input wire logic cfg_eos_en,
	input wire logic cfg_eoi_en,
	input wire logic cfg_cnt_en,
	input wire logic [15:0] cfg_count,
	// Received data.
	output logic rx_valid,
	output logic [7:0] rx_data,
	output logic rx_end,
	// Transmit data.
	input wire logic tx_valid,
	input wire logic [7:0] tx_data,
	input wire logic tx_last,
	output logic tx_ready,
	// Status.
	output logic talker,
	output logic listener
);
	import gat_pkg::*;
	typedef enum logic [1:0] {GAT_SEC_NONE, GAT_SEC_LISTEN, GAT_SEC_TALK} gat_sec_e;
	logic [4:0] addr_reg;
	logic sec_en_reg;
	logic [4:0] sec_addr_reg;
	logic [7:0] eos_reg;
	logic eos_en_reg, eoi_en_reg, cnt_en_reg;
	logic [15:0] count_reg;
	logic [15:0] rx_cnt_reg;
	logic hold_reg;
	logic tx_eos_reg;
	gat_sec_e sec_reg;
	logic is_listen, is_talk, is_sec, addr_hit, is_unl, is_unt;
	logic cmd_byte, data_byte, rx_take, rx_term, tx_fire;

	gat_addr_match u_match (
		.cmd(bus.dio),
		.my_addr(addr_reg),
		.is_listen(is_listen),
		.is_talk(is_talk),
		.is_sec(is_sec),
		.addr_hit(addr_hit),
		.is_unl(is_unl),
		.is_unt(is_unt)
	);

	function automatic logic cfg_eos_hit();
		return bus.dio == eos_reg;
	endfunction

	assign cmd_byte = bus.strobe && bus.atn;
	assign data_byte = bus.strobe && !bus.atn;
	assign rx_take = data_byte && listener && !hold_reg;
	assign rx_term = (cfg_eos_hit() && eos_en_reg) || (bus.eoi && eoi_en_reg) ||
		(cnt_en_reg && rx_cnt_reg + CNT_ONE >= count_reg);

	// Configuration storage.
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			addr_reg <= 5'h00;
			sec_en_reg <= 1'b0;
			sec_addr_reg <= 5'h00;
			eos_reg <= EOS_DEFAULT;
			eos_en_reg <= 1'b0;
			eoi_en_reg <= 1'b0;
			cnt_en_reg <= 1'b0;
			count_reg <= CNT_ZERO;
		end else if (cfg_load) begin
			addr_reg <= (cfg_addr > ADDR_MAX) ? ADDR_MAX : cfg_addr;
			sec_en_reg <= cfg_sec_en;
			sec_addr_reg <= cfg_sec_addr;
			eos_reg <= cfg_eos_char;
			eos_en_reg <= cfg_eos_en;
			eoi_en_reg <= cfg_eoi_en;
			cnt_en_reg <= cfg_cnt_en;
			count_reg <= cfg_count;
		end
	end

	// Addressing state.
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			talker <= 1'b0;
			listener <= 1'b0;
			sec_reg <= GAT_SEC_NONE;
		end else if (cmd_byte) begin
			sec_reg <= GAT_SEC_NONE;
			if (is_unl) begin
				listener <= 1'b0;
			end else if (is_unt) begin
				talker <= 1'b0;
			end else if (is_listen && addr_hit) begin
				if (sec_en_reg) begin
					sec_reg <= GAT_SEC_LISTEN;
				end else begin
					listener <= 1'b1;
				end
			end else if (is_talk) begin
				if (!addr_hit) begin
					talker <= 1'b0;
				end else if (sec_en_reg) begin
					sec_reg <= GAT_SEC_TALK;
				end else begin
					talker <= 1'b1;
				end
			end else if (is_sec && bus.dio[ADDR_MSB:ADDR_LSB] == sec_addr_reg) begin
				unique case (sec_reg)
					GAT_SEC_LISTEN: listener <= 1'b1;
					GAT_SEC_TALK: talker <= 1'b1;
					GAT_SEC_NONE: ;
				endcase
			end
		end
	end

	// Listener path.
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			rx_valid <= 1'b0;
			rx_data <= BYTE_ZERO;
			rx_end <= 1'b0;
			rx_cnt_reg <= CNT_ZERO;
			hold_reg <= 1'b0;
		end else begin
			rx_valid <= rx_take;
			rx_end <= rx_take && rx_term;
			if (rx_take) begin
				rx_data <= bus.dio;
			end
			if (cfg_load || !listener || (cmd_byte && is_unl)) begin
				rx_cnt_reg <= CNT_ZERO;
				hold_reg <= 1'b0;
			end else if (rx_take) begin
				rx_cnt_reg <= rx_term ? CNT_ZERO : rx_cnt_reg + CNT_ONE;
				hold_reg <= cnt_en_reg && rx_cnt_reg + CNT_ONE >= count_reg;
			end
		end
	end

	// Talker path.
	assign tx_fire = talker && !bus.atn && !bus.t_hold && tx_valid && !tx_eos_reg;
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			bus.t_strobe <= 1'b0;
			bus.t_dio <= BYTE_ZERO;
			bus.t_eoi <= 1'b0;
			tx_eos_reg <= 1'b0;
			tx_ready <= 1'b0;
		end else begin
			tx_ready <= talker && !bus.atn && !bus.t_hold && !tx_eos_reg && !tx_fire;
			if (tx_eos_reg && talker && !bus.atn && !bus.t_hold) begin
				bus.t_strobe <= 1'b1;
				bus.t_dio <= eos_reg;
				bus.t_eoi <= eoi_en_reg;
				tx_eos_reg <= 1'b0;
			end else if (tx_fire) begin
				bus.t_strobe <= 1'b1;
				bus.t_dio <= tx_data;
				bus.t_eoi <= eoi_en_reg && tx_last && !eos_en_reg;
				tx_eos_reg <= tx_last && eos_en_reg;
			end else begin
				bus.t_strobe <= 1'b0;
				bus.t_eoi <= 1'b0;
			end
			if (!talker) begin
				tx_eos_reg <= 1'b0;
			end
		end
	end

	assign bus.l_hold = hold_reg;
endmodule // gat_device

//--- core/gat_pkg.sv
package gat_pkg;
	localparam int ADDR_W = 5;
	localparam int DATA_W = 8;
	localparam int CNT_W = 16;
	localparam logic [4:0] ADDR_MAX = 5'h1e;
	localparam int ADDR_LSB = 0;
	localparam int ADDR_MSB = 4;
	localparam int LISTEN_FLAG_POS = 5;
	localparam int TALK_FLAG_POS = 6;
	localparam logic [1:0] GRP_LISTEN = 2'h1;
	localparam logic [1:0] GRP_TALK = 2'h2;
	localparam logic [1:0] GRP_SEC = 2'h3;
	localparam logic [7:0] LISTEN_BASE = 8'h20;
	localparam logic [7:0] TALK_BASE = 8'h40;
	localparam logic [7:0] SEC_BASE = 8'h60;
	localparam logic [6:0] CMD_UNLISTEN = 7'h3f;
	localparam logic [6:0] CMD_UNTALK = 7'h5f;
	localparam logic [7:0] EOS_DEFAULT = 8'h0a;
	localparam logic [CNT_W-1:0] CNT_ZERO = 16'h0000;
	localparam logic [CNT_W-1:0] CNT_ONE = 16'h0001;
	localparam logic [DATA_W-1:0] BYTE_ZERO = 8'h00;
	// Controller-side register map.
	localparam logic [3:0] REG_CMD = 4'h0;
	localparam logic [3:0] REG_DATA = 4'h1;
	localparam logic [3:0] REG_STATUS = 4'h2;
	localparam logic [3:0] REG_RXDATA = 4'h3;
	localparam int ST_BUSY = 0;
	localparam int ST_RXV = 1;
	localparam int ST_RXEND = 2;
endpackage

//--- tb/gat_checker.sv
`timescale 1ns/1ps
module gat_checker (
	// Clock, reset and bus.
	input wire logic mclk,
	input wire logic sys_rst,
	input wire logic [7:0] dio,
	input wire logic atn,
	input wire logic strobe,
	input wire logic t_eoi,
	input wire logic t_strobe,
	input wire logic t_hold,
	input wire logic l_hold
);
	default clocking @(posedge mclk); endclocking
	default disable iff (sys_rst);
	property p_atn; atn |=> !t_strobe; endproperty
	a_atn: assert property (p_atn) else $error("Talker sent during attention");
	property p_hold; t_hold |=> !t_strobe; endproperty
	a_hold: assert property (p_hold) else $error("Talker sent while held");
	property p_eoi; t_eoi |-> t_strobe; endproperty
	a_eoi: assert property (p_eoi) else $error("End line without a byte");
	property p_unl; strobe && atn && dio[6:0] == 7'h3f |=> !l_hold; endproperty
	a_unl: assert property (p_unl) else $error("Hold kept after unlisten");
	property p_rise; $rose(l_hold) |-> $past(strobe && !atn); endproperty
	a_rise: assert property (p_rise) else $error("Hold without data byte");
	property p_rst; $fell(sys_rst) |-> !t_strobe && !l_hold && !t_eoi; endproperty
	a_rst: assert property (p_rst) else $error("Outputs active after reset");
	property p_dat; t_eoi |-> !$past(atn); endproperty
	a_dat: assert property (p_dat) else $error("End line on command");
	property p_keep; l_hold && !(strobe && atn) |=> l_hold; endproperty
	a_keep: assert property (p_keep) else $error("Hold dropped early");
	c_eoi: cover property (t_eoi);
	c_hold: cover property ($rose(l_hold));
	c_cmd: cover property (strobe && atn);
endmodule // gat_checker

//--- tb/ieee488_addr_decode_term_bench.sv
`timescale 1ns/1ps
module ieee488_addr_decode_term_bench;
	logic mclk = 0, sys_rst = 1, ld = 0, sen = 0, een = 0, ien = 0, cen = 0;
	logic wr = 0, rd = 0, txv = 0, txl = 0, rxv, rxe, tk, ls, trdy;
	logic [4:0] ad = 5'h05, sa = 5'h03;
	logic [7:0] ec = 8'h0d, txd = 8'h00, rxd, lrx, eb;
	logic [15:0] cnt = 16'h0000, wd = 16'h0000, rdat;
	logic [3:0] ra = 4'h0;
	int fails = 0, checks = 0, nrx, nend, ntx, neoi;
	gat_bus_if i_gat_bus_if ();
	gat_device i_gat_device (.mclk(mclk), .sys_rst(sys_rst), .bus(i_gat_bus_if), .cfg_load(ld), .cfg_addr(ad),
		.cfg_sec_en(sen), .cfg_sec_addr(sa), .cfg_eos_char(ec), .cfg_eos_en(een), .cfg_eoi_en(ien),
		.cfg_cnt_en(cen), .cfg_count(cnt), .rx_valid(rxv), .rx_data(rxd), .rx_end(rxe), .tx_valid(txv),
		.tx_data(txd), .tx_last(txl), .tx_ready(trdy), .talker(tk), .listener(ls));
	gat_controller i_gat_controller (.mclk(mclk), .sys_rst(sys_rst), .reg_addr(ra), .reg_wdata(wd),
		.reg_wr(wr), .reg_rd(rd), .reg_rdata(rdat), .bus(i_gat_bus_if));
	gat_checker i_gat_checker (.mclk(mclk), .sys_rst(sys_rst), .dio(i_gat_bus_if.dio), .atn(i_gat_bus_if.atn),
		.strobe(i_gat_bus_if.strobe), .t_eoi(i_gat_bus_if.t_eoi), .t_strobe(i_gat_bus_if.t_strobe),
		.t_hold(i_gat_bus_if.t_hold), .l_hold(i_gat_bus_if.l_hold));
	always #25 mclk = ~mclk;
	always @(posedge mclk) begin
		if (rxv === 1'b1) begin
			nrx++;
			lrx = rxd;
		end
		if (rxe === 1'b1) nend++;
		if (i_gat_bus_if.t_strobe === 1'b1) ntx++;
		if (i_gat_bus_if.t_eoi === 1'b1) begin
			neoi++;
			eb = i_gat_bus_if.t_dio;
		end
	end
	task finish_test;
		$display("fails=%0d checks=%0d", fails, checks);
		if (fails == 0 && checks > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask
	task ck(input logic [15:0] g, input logic [15:0] e);
		checks++;
		if (g !== e) begin
			fails++;
			$display("ERROR %0t got %h exp %h", $time, g, e);
		end
	endtask
	task z;
		nrx = 0;
		nend = 0;
		ntx = 0;
		neoi = 0;
	endtask
	task w(input logic [3:0] a, input logic [15:0] d);
		@(posedge mclk) begin
			ra <= a;
			wd <= d;
			wr <= 1;
		end
		@(posedge mclk) wr <= 0;
	endtask
	task bw(input logic [3:0] a, input logic [15:0] d);
		int i;
		w(a, d);
		i = 0;
		@(posedge mclk);
		while (i_gat_bus_if.strobe !== 1'b1 && i < 20) begin
			i++;
			@(posedge mclk);
		end
		if (i >= 20) begin
			fails++;
			finish_test;
		end
		@(posedge mclk);
		#1;
	endtask
	task rg(input logic [3:0] a, input logic [15:0] e);
		@(posedge mclk) begin
			ra <= a;
			rd <= 1;
		end
		@(posedge mclk) rd <= 0;
		#1 ck(rdat, e);
	endtask
	task cf(input logic s, input logic e, input logic i, input logic c, input logic [15:0] n);
		@(posedge mclk) begin
			{sen, een, ien, cen, cnt} <= {s, e, i, c, n};
			ld <= 1;
		end
		@(posedge mclk) ld <= 0;
	endtask
	task tx(input logic [7:0] d, input logic l);
		@(posedge mclk) begin
			{txv, txd, txl} <= {1'b1, d, l};
		end
		@(posedge mclk) txv <= 0;
		repeat (3) @(posedge mclk);
		#1;
	endtask
	task t_addr;
		cf(0, 0, 0, 0, 16'h0000);
		bw(0, 16'h0025);
		ck(ls, 1);
		bw(0, 16'h0026);
		ck(ls, 1);
		bw(0, 16'h00bf);
		ck(ls, 0);
		bw(0, 16'h0045);
		ck(tk, 1);
		bw(0, 16'h0046);
		ck(tk, 0);
		bw(0, 16'h0045);
		bw(0, 16'h005f);
		ck(tk, 0);
	endtask
	task t_eos;
		cf(0, 1, 0, 0, 16'h0000);
		z;
		bw(1, 16'h0011);
		bw(0, 16'h0025);
		bw(0, 16'h000d);
		bw(1, 16'h0033);
		bw(1, 16'h000d);
		ck(nrx, 2);
		ck(nend, 1);
		ck(lrx, 8'h0d);
		rg(4'h2, 16'h0000);
		rg(4'h9, 16'h0000);
		bw(0, 16'h003f);
	endtask
	task t_end;
		cf(0, 0, 1, 0, 16'h0000);
		bw(0, 16'h0025);
		z;
		bw(1, 16'h000d);
		bw(1, 16'h0144);
		ck(nend, 1);
		ck(nrx, 2);
		bw(0, 16'h003f);
		cf(0, 1, 0, 1, 16'h0002);
		bw(0, 16'h0025);
		z;
		bw(1, 16'h0001);
		bw(1, 16'h0002);
		ck(nend, 1);
		ck(i_gat_bus_if.l_hold, 1);
		bw(0, 16'h003f);
		ck(i_gat_bus_if.l_hold, 0);
	endtask
	task t_tx;
		cf(0, 1, 1, 0, 16'h0000);
		bw(0, 16'h0045);
		bw(1, 16'h0000);
		ck(trdy, 1);
		w(2, 16'h0001);
		z;
		tx(8'haa, 0);
		ck(ntx, 0);
		ck(trdy, 0);
		w(2, 16'h0000);
		tx(8'haa, 0);
		tx(8'hbb, 1);
		ck(ntx, 3);
		ck(neoi, 1);
		ck(eb, 8'h0d);
		rg(4'h2, 16'h0006);
		rg(4'h3, 16'h000d);
		rg(4'h2, 16'h0004);
		bw(0, 16'h005f);
	endtask
	task t_sec;
		cf(1, 0, 0, 0, 16'h0000);
		bw(0, 16'h0025);
		bw(0, 16'h0063);
		ck(ls, 1);
		bw(0, 16'h003f);
		bw(0, 16'h0025);
		bw(0, 16'h0064);
		ck(ls, 0);
		cf(0, 0, 0, 0, 16'h0000);
		bw(0, 16'h0025);
		@(posedge mclk) sys_rst <= 1;
		@(posedge mclk) sys_rst <= 0;
		#1 ck(ls, 0);
	endtask
	initial begin
		repeat (12) @(posedge mclk);
		sys_rst <= 0;
		t_addr;
		t_eos;
		t_end;
		t_tx;
		t_sec;
		finish_test;
	end
endmodule // ieee488_addr_decode_term_bench
